// >>> design/imcr_pkg.sv
// imcr_pkg: constants for the inverter modbus control register slave.
// assumes one 20 MHz clock; byte stream comes from a uart outside this block.
package imcr_pkg;
  // clock and link timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BAUD = 115200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  // 3.5 character gap ends a frame (11 bits per character)
  localparam int unsigned GAP_CYC = (BIT_CYC * 11 * 7) / 2;
  // frame bytes and codes
  localparam logic [7:0] UNIT_ID_BASE = 8'hC0;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int unsigned MAX_REGS = 8;
  // register offsets
  localparam logic [15:0] A_LINE_FREQ = 16'h0056;
  localparam logic [15:0] A_FW_VER0 = 16'h008C;
  localparam logic [15:0] A_FW_VER2 = 16'h008E;
  localparam logic [15:0] A_CHG_CUR = 16'h00B0;
  localparam logic [15:0] A_CHG_VOLT = 16'h00B1;
  localparam logic [15:0] A_CURVE_OPT = 16'h00B4;
  localparam logic [15:0] A_BAT_ALM = 16'h00B9;
  localparam logic [15:0] A_UNLOCK = 16'h00CF;
  localparam logic [15:0] A_OUT_CTRL = 16'h0100;
  localparam logic [15:0] A_MODE_CFG = 16'h0101;
  localparam logic [15:0] A_OUT_VOLT = 16'h0102;
  localparam logic [15:0] A_OUT_FREQ = 16'h0103;
  localparam logic [15:0] A_OP_STATUS = 16'h011D;
  localparam logic [15:0] A_FAULTS = 16'h011E;
  // field layout, write masks and read masks
  localparam int unsigned OC_SWITCH = 0;
  localparam int unsigned OC_GATE = 1;
  localparam int unsigned OC_BYPASS_CHG = 2;
  localparam logic [15:0] OUT_CTRL_MASK = 16'h0007;
  localparam logic [15:0] OUT_CTRL_RST = 16'h0005;
  localparam logic [15:0] MODE_MASK = 16'h0003;
  localparam logic [1:0] PRIO_UPS = 2'h0;
  localparam logic [1:0] PRIO_SAVE = 2'h1;
  localparam int unsigned CURVE_STAGE_BIT = 6;
  localparam logic [15:0] CURVE_MASK = 16'h074F;
  localparam logic [15:0] CURVE_RST = 16'h0004;
  localparam logic [15:0] STATUS_MASK = 16'h037F;
  localparam logic [15:0] FAULT_MASK = 16'h1FFF;
endpackage

// >>> design/imcr_slave.sv
// imcr_slave: modbus rtu slave holding the inverter control and status registers.
// assumes a uart delivering received bytes as one-cycle strobes and taking
// transmit bytes with a valid/ready handshake; status inputs are synchronous.
`timescale 1ns/100ps
// Notes on behaviour
// - output_control bit 0 turns ac output on/off; resets to 1.
// - output_control bit 1 gates the switch bit; 0 ignores it; resets to 0.
// - output_control bit 2 runs charger in bypass; resets to 1.
// - operating_priority 00 ups default, 01 energy saving, 10/11 reserved.
// - unsupported bits read as zero.
// - status bit 0 output from converter, bit 1 output from utility.
// - status bit 2 mains present, bit 3 charger active.
// - status bit 4 solar charger control, low means enabled.
// - status bit 5 energy saving, bit 6 low battery warning.
// - status high bits 1:0 output phase select, 00 default.
// - fault bits 0..2 overload bands low, mid, high.
// - fault bits 3..7 overtemp, under-volt, over-volt, short, nvm error.
// - fault high bits 0..4 shutdown, fan, bat uv, bat ov, general; rest zero.
// - read holding: id, fc, addr, count, crc; reply id, fc, bytes, data, crc.
// - read input uses the same layout, code 0x04, two bytes per register.
// - single write stores value, then echoes the request frame.
// - crc on every frame, low byte first.
// - voltage/frequency settings writable only after the unlock key write.
// - output voltage setting of zero hands control to the selector switch.
// - new voltage/frequency settings apply only after a reboot.
// - writing 0x0040 to charge_curve_options selects two-stage charging.
// - charge_curve_options bit 6: 0 three-stage, 1 two-stage.
module imcr_slave #(
  parameter int unsigned GAP_CYC = imcr_pkg::GAP_CYC, // end-of-frame idle gap
  parameter logic [7:0] UNIT_ADDR = 8'h00, // low unit address bits, or'd onto UNIT_ID_BASE
  parameter logic [15:0] UNLOCK_KEY = 16'h1234, // unlock key, arbitrary value
  parameter logic [47:0] FW_VERSION = 48'h010203040506 // arbitrary value
) (
  input wire logic ref_clk_i, // system clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic rx_valid_i, // received byte strobe
  input wire logic [7:0] rx_data_i, // received byte
  output logic tx_valid_o, // transmit byte valid
  output logic [7:0] tx_data_o, // transmit byte
  input wire logic tx_ready_i, // uart takes byte
  input wire logic reboot_i, // inverter restart pulse
  input wire logic [15:0] status_i, // live operating status
  input wire logic [15:0] faults_i, // live fault bits
  input wire logic [15:0] line_freq_i, // measured line frequency
  output logic ac_output_on_o, // ac output request
  output logic bypass_charger_en_o, // charger allowed in bypass
  output logic [1:0] operating_priority_o, // mode select
  output logic charge_stage_count_o, // 1 = two-stage charging
  output logic [15:0] charge_current_o, // charge current setpoint
  output logic [15:0] charge_voltage_o, // charge voltage setpoint
  output logic [15:0] battery_alarm_o, // battery alarm threshold
  output logic [15:0] out_volt_applied_o, // output voltage in force
  output logic [15:0] out_freq_applied_o, // output frequency in force
  output logic use_voltage_selector_o // voltage from selector switch
);

  typedef enum logic [1:0] {
    IMCR_RX = 2'b00,
    IMCR_EXEC = 2'b01,
    IMCR_TX = 2'b10
  } imcr_state_e;

  imcr_state_e state_q;
  logic [7:0] frm_q [0:7];
  logic [3:0] rx_cnt_q;
  logic [15:0] rx_crc_q;
  logic [$clog2(GAP_CYC+1)-1:0] gap_q;
  logic in_frame_q;
  logic [7:0] tx_buf_q [0:20];
  logic [4:0] tx_len_q;
  logic [4:0] tx_idx_q;
  logic [15:0] tx_crc_q;
  logic [15:0] out_ctrl_q;
  logic [1:0] prio_q;
  logic [15:0] curve_q, chg_cur_q, chg_volt_q, bat_alm_q;
  logic [15:0] out_volt_q, out_freq_q, out_volt_act_q, out_freq_act_q;
  logic unlocked_q;
  logic sw_state_q;

  // crc step for one byte, reflected polynomial
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ imcr_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // register read mux; unsupported bits masked to zero
  function automatic logic [16:0] reg_rd(input logic [15:0] a);
    logic [16:0] r;
    r = {1'b1, 16'h0000};
    unique case (a)
      imcr_pkg::A_LINE_FREQ: r[15:0] = line_freq_i;
      imcr_pkg::A_FW_VER0: r[15:0] = FW_VERSION[47:32];
      imcr_pkg::A_FW_VER0 + 16'h0001: r[15:0] = FW_VERSION[31:16];
      imcr_pkg::A_FW_VER2: r[15:0] = FW_VERSION[15:0];
      imcr_pkg::A_CHG_CUR: r[15:0] = chg_cur_q;
      imcr_pkg::A_CHG_VOLT: r[15:0] = chg_volt_q;
      imcr_pkg::A_CURVE_OPT: r[15:0] = curve_q;
      imcr_pkg::A_BAT_ALM: r[15:0] = bat_alm_q;
      imcr_pkg::A_OUT_CTRL: r[15:0] = out_ctrl_q;
      imcr_pkg::A_MODE_CFG: r[15:0] = {14'h0000, prio_q};
      imcr_pkg::A_OUT_VOLT: r[15:0] = out_volt_q;
      imcr_pkg::A_OUT_FREQ: r[15:0] = out_freq_q;
      imcr_pkg::A_OP_STATUS: r[15:0] = status_i & imcr_pkg::STATUS_MASK;
      imcr_pkg::A_FAULTS: r[15:0] = faults_i & imcr_pkg::FAULT_MASK;
      default: r = 17'h00000;
    endcase
    return r;
  endfunction

  // existence flag of one register; a call result is never indexed directly
  function automatic logic reg_exists(input logic [15:0] a);
    logic [16:0] r;
    r = reg_rd(a);
    return r[16];
  endfunction

  // high or low byte of one register value
  function automatic logic [7:0] reg_byte(input logic [15:0] a, input logic hi);
    logic [16:0] r;
    r = reg_rd(a);
    return hi ? r[15:8] : r[7:0];
  endfunction

  // decoded request fields
  logic [7:0] fc;
  logic [15:0] req_addr, req_val;
  logic unit_hit, crc_ok, fc_ok, addr_ok, wr_ok, rd_range_ok;
  assign fc = frm_q[1];
  assign req_addr = {frm_q[2], frm_q[3]};
  assign req_val = {frm_q[4], frm_q[5]};
  assign unit_hit = frm_q[0] == (imcr_pkg::UNIT_ID_BASE | UNIT_ADDR);
  assign crc_ok = rx_cnt_q == 4'd8 && rx_crc_q == 16'h0000;
  assign fc_ok = fc == imcr_pkg::FC_RD_HOLD || fc == imcr_pkg::FC_RD_INPUT ||
                 fc == imcr_pkg::FC_WR_SINGLE;
  assign rd_range_ok = req_val != 16'h0000 && req_val <= 16'(imcr_pkg::MAX_REGS);

  // write target check; locked settings refuse as an address error
  always_comb begin
    wr_ok = 1'b1;
    unique case (req_addr)
      imcr_pkg::A_CHG_CUR, imcr_pkg::A_CHG_VOLT, imcr_pkg::A_CURVE_OPT,
      imcr_pkg::A_BAT_ALM, imcr_pkg::A_UNLOCK, imcr_pkg::A_OUT_CTRL,
      imcr_pkg::A_MODE_CFG: wr_ok = 1'b1;
      imcr_pkg::A_OUT_VOLT, imcr_pkg::A_OUT_FREQ: wr_ok = unlocked_q;
      default: wr_ok = 1'b0;
    endcase
  end

  // every register of a read range must exist
  always_comb begin
    addr_ok = rd_range_ok;
    for (int i = 0; i < imcr_pkg::MAX_REGS; i++) begin
      if (16'(i) < req_val && !reg_exists(req_addr + 16'(i))) begin
        addr_ok = 1'b0;
      end
    end
  end

  logic do_write;
  assign do_write = state_q == IMCR_EXEC && unit_hit && crc_ok &&
                    fc == imcr_pkg::FC_WR_SINGLE && wr_ok;

  // frame receiver: bytes collect until the line idles for the gap time
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_cnt_q <= 4'd0;
      rx_crc_q <= imcr_pkg::CRC_INIT;
      gap_q <= '0;
      in_frame_q <= 1'b0;
    end else if (state_q == IMCR_RX) begin
      if (rx_valid_i) begin
        if (rx_cnt_q < 4'd8) begin
          frm_q[rx_cnt_q[2:0]] <= rx_data_i;
        end
        rx_cnt_q <= (rx_cnt_q == 4'd15) ? rx_cnt_q : rx_cnt_q + 4'd1;
        rx_crc_q <= crc_byte(rx_crc_q, rx_data_i);
        gap_q <= '0;
        in_frame_q <= 1'b1;
      end else if (in_frame_q && gap_q != GAP_CYC[$bits(gap_q)-1:0]) begin
        gap_q <= gap_q + 1'b1;
      end
    end else begin
      rx_cnt_q <= 4'd0;
      rx_crc_q <= imcr_pkg::CRC_INIT;
      gap_q <= '0;
      in_frame_q <= 1'b0;
    end
  end

  // frame sequencer
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= IMCR_RX;
    end else begin
      unique case (state_q)
        IMCR_RX: if (in_frame_q && gap_q == GAP_CYC[$bits(gap_q)-1:0]) state_q <= IMCR_EXEC;
        IMCR_EXEC: state_q <= (unit_hit && crc_ok) ? IMCR_TX : IMCR_RX;
        IMCR_TX: if (tx_ready_i && tx_idx_q == tx_len_q + 5'd1) state_q <= IMCR_RX;
        default: state_q <= IMCR_RX;
      endcase
    end
  end

  // reply builder and sender, crc appended low byte first
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tx_len_q <= 5'd0;
      tx_idx_q <= 5'd0;
      tx_crc_q <= imcr_pkg::CRC_INIT;
    end else if (state_q == IMCR_EXEC) begin
      tx_idx_q <= 5'd0;
      tx_crc_q <= imcr_pkg::CRC_INIT;
      tx_buf_q[0] <= frm_q[0];
      if (!fc_ok || (fc != imcr_pkg::FC_WR_SINGLE && !addr_ok) ||
          (fc == imcr_pkg::FC_WR_SINGLE && !wr_ok)) begin
        tx_buf_q[1] <= fc | imcr_pkg::EXC_FLAG;
        tx_buf_q[2] <= fc_ok ? imcr_pkg::EXC_ILL_ADDR : imcr_pkg::EXC_ILL_FUNC;
        tx_len_q <= 5'd3;
      end else if (fc == imcr_pkg::FC_WR_SINGLE) begin
        for (int i = 1; i < 6; i++) tx_buf_q[i] <= frm_q[i];
        tx_len_q <= 5'd6;
      end else begin
        tx_buf_q[1] <= fc;
        tx_buf_q[2] <= {req_val[6:0], 1'b0};
        for (int i = 0; i < imcr_pkg::MAX_REGS; i++) begin
          tx_buf_q[3+2*i] <= reg_byte(req_addr + 16'(i), 1'b1);
          tx_buf_q[4+2*i] <= reg_byte(req_addr + 16'(i), 1'b0);
        end
        tx_len_q <= 5'(3 + 2 * req_val[3:0]);
      end
    end else if (state_q == IMCR_TX && tx_ready_i) begin
      tx_idx_q <= tx_idx_q + 5'd1;
      if (tx_idx_q < tx_len_q) tx_crc_q <= crc_byte(tx_crc_q, tx_buf_q[tx_idx_q]);
    end
  end

  // outgoing byte selection: body, then crc low, then crc high
  always_comb begin
    tx_valid_o = state_q == IMCR_TX;
    if (tx_idx_q < tx_len_q) tx_data_o = tx_buf_q[tx_idx_q];
    else if (tx_idx_q == tx_len_q) tx_data_o = tx_crc_q[7:0];
    else tx_data_o = tx_crc_q[15:8];
  end

  // plain setting registers; unsupported bits never stored
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_ctrl_q <= imcr_pkg::OUT_CTRL_RST;
      prio_q <= imcr_pkg::PRIO_UPS;
      curve_q <= imcr_pkg::CURVE_RST;
      chg_cur_q <= 16'h0000;
      chg_volt_q <= 16'h0000;
      bat_alm_q <= 16'h0000;
    end else if (do_write) begin
      unique case (req_addr)
        imcr_pkg::A_OUT_CTRL: out_ctrl_q <= req_val & imcr_pkg::OUT_CTRL_MASK;
        imcr_pkg::A_MODE_CFG: prio_q <= req_val[1:0];
        imcr_pkg::A_CURVE_OPT: curve_q <= req_val & imcr_pkg::CURVE_MASK;
        imcr_pkg::A_CHG_CUR: chg_cur_q <= req_val;
        imcr_pkg::A_CHG_VOLT: chg_volt_q <= req_val;
        imcr_pkg::A_BAT_ALM: bat_alm_q <= req_val;
        default: ;
      endcase
    end
  end

  // unlock gate: opens on key, closes after one protected write
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      unlocked_q <= 1'b0;
    end else if (do_write && req_addr == imcr_pkg::A_UNLOCK) begin
      unlocked_q <= req_val == UNLOCK_KEY;
    end else if (do_write && (req_addr == imcr_pkg::A_OUT_VOLT ||
                              req_addr == imcr_pkg::A_OUT_FREQ)) begin
      unlocked_q <= 1'b0;
    end
  end

  // stored settings apply only at reboot
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_volt_q <= 16'h0000;
      out_freq_q <= 16'h0000;
      out_volt_act_q <= 16'h0000;
      out_freq_act_q <= 16'h0000;
    end else begin
      if (do_write && req_addr == imcr_pkg::A_OUT_VOLT) out_volt_q <= req_val;
      if (do_write && req_addr == imcr_pkg::A_OUT_FREQ) out_freq_q <= req_val;
      if (reboot_i) begin
        out_volt_act_q <= out_volt_q;
        out_freq_act_q <= out_freq_q;
      end
    end
  end

  // output switch state follows the switch bit only while gated
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sw_state_q <= 1'b1;
    end else if (out_ctrl_q[imcr_pkg::OC_GATE]) begin
      sw_state_q <= out_ctrl_q[imcr_pkg::OC_SWITCH];
    end
  end

  assign ac_output_on_o = sw_state_q;
  assign bypass_charger_en_o = out_ctrl_q[imcr_pkg::OC_BYPASS_CHG];
  assign operating_priority_o = prio_q;
  assign charge_stage_count_o = curve_q[imcr_pkg::CURVE_STAGE_BIT];
  assign charge_current_o = chg_cur_q;
  assign charge_voltage_o = chg_volt_q;
  assign battery_alarm_o = bat_alm_q;
  assign out_volt_applied_o = out_volt_act_q;
  assign out_freq_applied_o = out_freq_act_q;
  assign use_voltage_selector_o = out_volt_act_q == 16'h0000;

  // checks
  gate_holds_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !out_ctrl_q[imcr_pkg::OC_GATE] |=> $stable(sw_state_q))
    else $error("switch moved while gate low");
  gate_follows_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    out_ctrl_q[imcr_pkg::OC_GATE] |=> sw_state_q == $past(out_ctrl_q[0]))
    else $error("switch did not follow bit");
  charger_map_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    do_write && req_addr == imcr_pkg::A_OUT_CTRL |=> bypass_charger_en_o == $past(req_val[2]))
    else $error("charger enable mismatch");
  prio_range_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    do_write && req_addr == imcr_pkg::A_MODE_CFG |=> prio_q == $past(req_val[1:0]))
    else $error("priority not stored");
  ctrl_unused_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    out_ctrl_q[15:3] == 13'h0000)
    else $error("unsupported control bits set");
  locked_write_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !unlocked_q && state_q == IMCR_EXEC && req_addr == imcr_pkg::A_OUT_VOLT
    |=> $stable(out_volt_q))
    else $error("locked voltage setting changed");
  reboot_only_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !$past(reboot_i) |-> $stable(out_volt_act_q) && $stable(out_freq_act_q))
    else $error("setting applied without reboot");
  selector_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    reboot_i && out_volt_q == 16'h0000 |=> use_voltage_selector_o)
    else $error("selector not handed control");
  bad_crc_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == IMCR_EXEC && !crc_ok |=> state_q == IMCR_RX ##1 !tx_valid_o)
    else $error("reply sent for bad frame");
  stage_bit_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    do_write && req_addr == imcr_pkg::A_CURVE_OPT && req_val == 16'h0040
    |=> charge_stage_count_o)
    else $error("two-stage not selected");
  write_cov_c: cover property (@(posedge ref_clk_i) do_write);
  unlock_cov_c: cover property (@(posedge ref_clk_i) unlocked_q ##1 !unlocked_q);
  reply_cov_c: cover property (@(posedge ref_clk_i) state_q == IMCR_TX ##1 state_q == IMCR_RX);
endmodule

// >>> testbench/imcr_master_model.sv
// imcr_master_model: modbus rtu master on the slave's received/transmit byte ports.
// assumes one clock shared with the slave; bytes are driven 1 ns after a rising edge.
`timescale 1ns/100ps
module imcr_master_model (
  input wire logic clk_i, // bench clock
  output logic rx_valid_o, // byte strobe to slave
  output logic [7:0] rx_data_o, // byte to slave
  input wire logic tx_valid_i, // reply byte valid
  input wire logic [7:0] tx_data_i, // reply byte
  output logic tx_ready_o // reply byte taken
);
  logic [7:0] rsp [0:31]; // collected reply
  int rsp_n; // reply length
  logic crc_ok; // reply crc matched
  logic slow; // drop ready on every other cycle of the reply

  // idle levels at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b0;
    rsp_n = 0;
    crc_ok = 1'b0;
    slow = 1'b0;
  end

  // crc16 over n bytes, reflected polynomial
  function automatic logic [15:0] crc16(input logic [7:0] b [0:31], input int n);
    logic [15:0] c;
    c = imcr_pkg::CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ imcr_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // one request of six bytes plus crc, then collect the reply under a bound
  task automatic xfer(input logic [47:0] pdu, input logic bad_crc);
    logic [7:0] f [0:31];
    logic [15:0] c;
    for (int i = 0; i < 6; i++) f[i] = pdu[47 - 8 * i -: 8];
    c = crc16(f, 6) ^ {15'h0000, bad_crc};
    f[6] = c[7:0];
    f[7] = c[15:8];
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b1;
      rx_data_o = f[i];
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b0;
      rx_data_o = ~f[i]; // no stale byte left on the line
    end
    rsp_n = 0;
    // ready chosen here holds through the next edge, so a byte seen now is taken there;
    // the exit test comes first so ready is written once per time step
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_i);
      #1;
      if (k == 199 || (rsp_n > 0 && tx_valid_i !== 1'b1)) break;
      tx_ready_o = slow ? ~tx_ready_o : 1'b1;
      if (tx_valid_i === 1'b1 && tx_ready_o && rsp_n < 32) begin
        rsp[rsp_n] = tx_data_i;
        rsp_n++;
      end
    end
    tx_ready_o = 1'b0;
    crc_ok = rsp_n > 2 && crc16(rsp, rsp_n - 2) === {rsp[rsp_n - 1], rsp[rsp_n - 2]};
  endtask
endmodule

// >>> testbench/tb.sv
// tb: register-level test of the modbus control register slave through the master model.
// assumes a short end-of-frame gap so each answered frame takes under a hundred cycles.
`timescale 1ns/100ps
module tb;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
  localparam logic [15:0] KEY = 16'h2B6E; // unlock key, arbitrary value
  localparam logic [47:0] FWV = 48'h112233445566; // arbitrary value
  logic ref_clk_i;
  logic srst_i;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic reboot;
  logic [15:0] status;
  logic [15:0] faults;
  logic [15:0] line_freq;
  logic ac_on;
  logic bypass_chg;
  logic [1:0] prio;
  logic two_stage;
  logic [15:0] chg_cur;
  logic [15:0] chg_volt;
  logic [15:0] bat_alm;
  logic [15:0] volt_app;
  logic [15:0] freq_app;
  logic use_sel;
  logic [7:0] eb [0:31];
  int n_fail;
  int n_compared;

  imcr_slave #(.GAP_CYC(20), .UNIT_ADDR(8'h00), .UNLOCK_KEY(KEY), .FW_VERSION(FWV)) i_dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .reboot_i(reboot),
    .status_i(status), .faults_i(faults), .line_freq_i(line_freq), .ac_output_on_o(ac_on),
    .bypass_charger_en_o(bypass_chg), .operating_priority_o(prio),
    .charge_stage_count_o(two_stage), .charge_current_o(chg_cur),
    .charge_voltage_o(chg_volt), .battery_alarm_o(bat_alm), .out_volt_applied_o(volt_app),
    .out_freq_applied_o(freq_app), .use_voltage_selector_o(use_sel));

  imcr_master_model i_mst (.clk_i(ref_clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));

  // 20 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // reply must match eb for n bytes plus a good crc; a missing reply ends the run
  task automatic chk_rsp(input int n);
    `CHK("reply length", n + 2, i_mst.rsp_n)
    if (i_mst.rsp_n == 0) report_and_stop();
    for (int i = 0; i < n; i++) `CHK("reply byte", eb[i], i_mst.rsp[i])
    `CHK("reply crc", 1'b1, i_mst.crc_ok)
  endtask

  task automatic rd(input logic [7:0] fc, input logic [15:0] a, input int cnt,
                    input logic [47:0] w);
    eb[0] = 8'hC0;
    eb[1] = fc;
    eb[2] = 8'(2 * cnt);
    for (int i = 0; i < 2 * cnt; i++) eb[3 + i] = w[47 - 8 * i -: 8];
    i_mst.xfer({8'hC0, fc, a, 16'(cnt)}, 1'b0);
    chk_rsp(3 + 2 * cnt);
  endtask

  // a normal write answers with the echo of the request
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    logic [47:0] p;
    p = {8'hC0, imcr_pkg::FC_WR_SINGLE, a, v};
    for (int i = 0; i < 6; i++) eb[i] = p[47 - 8 * i -: 8];
    i_mst.xfer(p, 1'b0);
    chk_rsp(6);
  endtask

  task automatic ex(input logic [47:0] pdu, input logic [7:0] code);
    eb[0] = 8'hC0;
    eb[1] = pdu[39:32] | imcr_pkg::EXC_FLAG;
    eb[2] = code;
    i_mst.xfer(pdu, 1'b0);
    chk_rsp(3);
  endtask

  task automatic silent(input logic [47:0] pdu, input logic bad);
    i_mst.xfer(pdu, bad);
    `CHK("no reply", 0, i_mst.rsp_n)
  endtask

  task automatic pulse_reboot();
    @(posedge ref_clk_i);
    #1 reboot = 1'b1;
    @(posedge ref_clk_i);
    #1 reboot = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_fail++;
    report_and_stop();
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    srst_i = 1'b1;
    reboot = 1'b0;
    status = 16'h0000;
    faults = 16'h0000;
    line_freq = 16'h1770;
    repeat (2) @(posedge ref_clk_i);
    #1 srst_i = 1'b0;
    `CHK("switch rst", 1'b1, ac_on)
    `CHK("charger rst", 1'b1, bypass_chg)
    `CHK("prio rst", 2'b00, prio)
    `CHK("selector rst", 1'b1, use_sel)
    rd(8'h03, 16'h0100, 1, {16'h0005, 32'h0});
    rd(8'h03, 16'h0101, 1, {16'h0000, 32'h0});
    // gate low: switch bit ignored, charger bit still acts
    wr(16'h0100, 16'h0000);
    `CHK("gate off", 1'b1, ac_on)
    `CHK("charger off", 1'b0, bypass_chg)
    wr(16'h0100, 16'h0002);
    `CHK("remote off", 1'b0, ac_on)
    wr(16'h0100, 16'hFFFF);
    `CHK("remote on", 1'b1, ac_on)
    rd(8'h03, 16'h0100, 1, {16'h0007, 32'h0});
    wr(16'h0101, 16'h0001);
    `CHK("saving mode", 2'b01, prio)
    wr(16'h0101, 16'h0000);
    `CHK("ups mode", 2'b00, prio)
    // complementary patterns so every status and fault bit reads both ways
    for (int i = 0; i < 2; i++) begin
      status = i ? 16'h5A5A : 16'hA5A5;
      faults = ~status;
      rd(8'h04, 16'h011D, 2, {status & 16'h037F, faults & 16'h1FFF, 16'h0});
    end
    rd(8'h04, 16'h0056, 1, {16'h1770, 32'h0});
    rd(8'h03, 16'h008C, 3, FWV);
    wr(16'h00B9, 16'h0FA0);
    `CHK("alarm level", 16'h0FA0, bat_alm)
    wr(16'h00B0, 16'h1388);
    `CHK("charge current", 16'h1388, chg_cur)
    wr(16'h00B1, 16'h15E0);
    `CHK("charge voltage", 16'h15E0, chg_volt)
    wr(16'h00B4, 16'h0040);
    `CHK("two stage", 1'b1, two_stage)
    rd(8'h03, 16'h00B4, 1, {16'h0040, 32'h0});
    // protected settings: locked, then one write per unlock, applied on reboot
    ex({8'hC0, 8'h06, 16'h0102, 16'h00E6}, 8'h02);
    wr(16'h00CF, KEY);
    wr(16'h0102, 16'h00E6);
    `CHK("volt before reboot", 16'h0000, volt_app)
    ex({8'hC0, 8'h06, 16'h0102, 16'h00F0}, 8'h02);
    pulse_reboot();
    `CHK("volt applied", 16'h00E6, volt_app)
    `CHK("selector off", 1'b0, use_sel)
    wr(16'h00CF, KEY);
    wr(16'h0103, 16'h0032);
    `CHK("freq before reboot", 16'h0000, freq_app)
    pulse_reboot();
    `CHK("freq applied", 16'h0032, freq_app)
    wr(16'h00CF, KEY);
    wr(16'h0102, 16'h0000);
    pulse_reboot();
    `CHK("selector on", 1'b1, use_sel)
    // refused frames leave state alone
    silent({8'hC0, 8'h06, 16'h0100, 16'h0002}, 1'b1);
    silent({8'hC1, 8'h06, 16'h0100, 16'h0002}, 1'b0);
    `CHK("refused write", 1'b1, ac_on)
    ex({8'hC0, 8'h05, 16'h0100, 16'hFF00}, 8'h01);
    ex({8'hC0, 8'h03, 16'h0200, 16'h0001}, 8'h02);
    ex({8'hC0, 8'h03, 16'h00CF, 16'h0001}, 8'h02);
    ex({8'hC0, 8'h04, 16'h0100, 16'h0009}, 8'h02);
    // slow master: each reply byte must stand until taken
    i_mst.slow = 1'b1;
    rd(8'h03, 16'h008C, 3, FWV);
    i_mst.slow = 1'b0;
    report_and_stop();
  end
endmodule
